//--- adc_pkg.sv
// Constants for the converter sequencing control block
// Assumes AXI4-Lite with 32-bit data and a 50 MHz clock
package adc_pkg;
    localparam int ADC_ADDR_W = 16;
    localparam int ADC_IDX_W = 14;
    localparam int ADC_CH_W = 3;
    localparam int ADC_RES_W = 10;
    // Register indexes; byte address is four times the index
    localparam logic [ADC_IDX_W-1:0] IDX_PRI_RES_LO = 14'h12B0;
    localparam logic [ADC_IDX_W-1:0] IDX_PRI_RES_HI = 14'h12B1;
    localparam logic [ADC_IDX_W-1:0] IDX_CMP0_LO = 14'h12B4;
    localparam logic [ADC_IDX_W-1:0] IDX_CMP0_HI = 14'h12B5;
    localparam logic [ADC_IDX_W-1:0] IDX_CMP1_LO = 14'h12B6;
    localparam logic [ADC_IDX_W-1:0] IDX_CMP1_HI = 14'h12B7;
    localparam logic [ADC_IDX_W-1:0] IDX_NORM_CTRL = 14'h12B8;
    localparam logic [ADC_IDX_W-1:0] IDX_CH_MODE = 14'h12B9;
    localparam logic [ADC_IDX_W-1:0] IDX_PRI_CTRL = 14'h12BA;
    localparam logic [ADC_IDX_W-1:0] IDX_PRI_CH = 14'h12BB;
    localparam logic [ADC_IDX_W-1:0] IDX_MON_CTRL = 14'h12BC;
    localparam logic [ADC_IDX_W-1:0] IDX_MON_CH = 14'h12BD;
    localparam logic [ADC_IDX_W-1:0] IDX_CCLK = 14'h12BF;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int B_END = 7;
    localparam int B_BUSY = 6;
    localparam int B_IDLE_OP = 4;
    localparam int B_START = 3;
    localparam int B_HW_EN = 2;
    localparam int B_REF = 7;
    localparam int B_LAT = 3;
    localparam int B_ITM = 2;
    localparam int B_REPEAT = 1;
    localparam int B_SCAN = 0;
    localparam int B_OVR = 1;
    localparam int B_STORED = 0;
    localparam logic [1:0] TRIG_TIMER = 2'h0;
    localparam logic [1:0] TRIG_PIN = 2'h2;
    localparam logic [1:0] TRIG_AUDIO = 2'h3;
    localparam logic [2:0] DIV_RESERVED = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : adc_pkg

//--- adc_monitor.sv
// Compare monitor: flags a result of its channel meeting the criterion
// Assumes results arrive as one-cycle valid pulses on the same clock
`timescale 1ns/100ps
module adc_monitor (
    // Settings
    input wire logic enable,
    input wire logic greater,
    input wire logic [adc_pkg::ADC_CH_W-1:0] channel,
    input wire logic [adc_pkg::ADC_RES_W-1:0] criterion,
    // Result stream
    input wire logic res_valid,
    input wire logic [adc_pkg::ADC_CH_W-1:0] res_channel,
    input wire logic [adc_pkg::ADC_RES_W-1:0] res_data,
    // Match
    output logic hit
);
    import adc_pkg::*;
    logic cmp_ok;
    always_comb begin
        cmp_ok = greater ? (res_data >= criterion) : (res_data <= criterion);
        hit = enable && res_valid && (res_channel == channel) && cmp_ok;
    end
endmodule : adc_monitor

//--- adc_seq_ctrl.sv
// Converter sequencing control with AXI4-Lite register slave
// Assumes converter and triggers on aclk, except the external trigger pin
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module adc_seq_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [adc_pkg::ADC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [adc_pkg::ADC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Triggers and standby
    input wire logic timer_trigger_normal,
    input wire logic timer_trigger_priority,
    input wire logic audio_sample_tick,
    input wire logic external_trigger_pin,
    input wire logic idle_standby_state,
    // Converter
    output logic conv_clk_en,
    output logic conv_start,
    output logic [adc_pkg::ADC_CH_W-1:0] conv_channel,
    output logic reference_apply,
    input wire logic conv_done,
    input wire logic [adc_pkg::ADC_RES_W-1:0] conv_data,
    // Normal result stream
    output logic result_valid,
    output logic [adc_pkg::ADC_CH_W-1:0] result_channel,
    output logic [adc_pkg::ADC_RES_W-1:0] result_data,
    input wire logic normal_result_read,
    // Monitor interrupts
    output logic monitor0_irq,
    output logic monitor1_irq
);
    import adc_pkg::*;

    logic [7:0] norm_ctrl, ch_mode, pri_ctrl, pri_ch, mon_ctrl, mon_ch;
    logic [2:0] conv_clock_divider_field;
    logic [ADC_RES_W-1:0] crit0, crit1, priority_result_bits;
    logic priority_overrun_flag, priority_stored_flag;
    logic normal_end_flag, seq_active, priority_end_flag, priority_busy_flag;
    logic pri_pend, in_conv, conv_is_pri, wait_read;
    logic [ADC_CH_W-1:0] nch;
    logic aw_hold, w_hold;
    logic [ADC_IDX_W-1:0] wr_idx;
    logic [7:0] wr_data;
    logic wr_lane;
    logic ext_s1, ext_s2, ext_s3;
    logic [2:0] div_cnt;
    logic [2:0] div_n;
    logic wr_en, rd_take, rd_pri_hi, normal_go, pri_go, run_ok, last_ch, pri_done, norm_done;
    logic [1:0] mon_hit, mon_status;
    logic [ADC_IDX_W-1:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_hit;

    // Bus side conditions
    always_comb begin
        wr_en = aw_hold && w_hold && !s_axi_bvalid;
        rd_take = s_axi_arvalid && s_axi_arready;
        rd_idx = s_axi_araddr[ADC_ADDR_W-1:2];
        rd_pri_hi = rd_take && (rd_idx == IDX_PRI_RES_HI);
    end

    // Write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            wr_idx <= '0;
            wr_data <= 8'h00;
            wr_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_idx <= s_axi_awaddr[ADC_ADDR_W-1:2];
            end else if (!aw_hold && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end else if (!w_hold && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
            end
        end
    end

    function automatic logic wr_hit(input logic [ADC_IDX_W-1:0] i);
        wr_hit = (i >= IDX_CMP0_LO && i <= IDX_MON_CH) || (i == IDX_CCLK);
    endfunction : wr_hit

    // Writable configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            norm_ctrl <= REG_RESET;
            ch_mode <= REG_RESET;
            pri_ctrl <= REG_RESET;
            pri_ch <= REG_RESET;
            mon_ctrl <= REG_RESET;
            mon_ch <= REG_RESET;
            conv_clock_divider_field <= 3'h0;
            crit0 <= '0;
            crit1 <= '0;
        end else if (wr_en && wr_lane) begin
            case (wr_idx)
                IDX_CMP0_LO: crit0[1:0] <= wr_data[7:6];
                IDX_CMP0_HI: crit0[9:2] <= wr_data;
                IDX_CMP1_LO: crit1[1:0] <= wr_data[7:6];
                IDX_CMP1_HI: crit1[9:2] <= wr_data;
                IDX_NORM_CTRL: norm_ctrl <= {3'h0, wr_data[4], 1'b0, wr_data[2:0]};
                IDX_CH_MODE: ch_mode <= wr_data;
                IDX_PRI_CTRL: pri_ctrl <= {4'h0, 1'b0, wr_data[2:0]};
                IDX_PRI_CH: pri_ch <= {1'b0, wr_data[6:4], 4'h0};
                IDX_MON_CTRL: mon_ctrl <= {wr_data[7:2], 2'h0};
                IDX_MON_CH: mon_ch <= {1'b0, wr_data[6:4], 1'b0, wr_data[2:0]};
                IDX_CCLK: conv_clock_divider_field <= wr_data[2:0];
                default: ;
            endcase
        end
    end

    // Read data path
    always_comb begin
        rd_hit = 1'b1;
        case (rd_idx)
            IDX_PRI_RES_LO: rd_byte = {priority_result_bits[1:0], 4'h0,
                priority_overrun_flag, priority_stored_flag};
            IDX_PRI_RES_HI: rd_byte = priority_result_bits[9:2];
            IDX_CMP0_LO: rd_byte = {crit0[1:0], 6'h00};
            IDX_CMP0_HI: rd_byte = crit0[9:2];
            IDX_CMP1_LO: rd_byte = {crit1[1:0], 6'h00};
            IDX_CMP1_HI: rd_byte = crit1[9:2];
            IDX_NORM_CTRL: rd_byte = {normal_end_flag, seq_active, norm_ctrl[5:0]};
            IDX_CH_MODE: rd_byte = ch_mode;
            IDX_PRI_CTRL: rd_byte = {priority_end_flag, priority_busy_flag, pri_ctrl[5:0]};
            IDX_PRI_CH: rd_byte = pri_ch;
            IDX_MON_CTRL: rd_byte = {mon_ctrl[7:2], mon_status};
            IDX_MON_CH: rd_byte = mon_ch;
            IDX_CCLK: rd_byte = {5'h00, conv_clock_divider_field};
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // External trigger pin synchroniser and edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= external_trigger_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // Conversion clock divider
    always_comb begin
        div_n = (conv_clock_divider_field == DIV_RESERVED) ? 3'h1 : conv_clock_divider_field;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 3'h0;
            conv_clk_en <= 1'b0;
        end else if (div_cnt >= div_n - 3'h1) begin
            div_cnt <= 3'h0;
            conv_clk_en <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 3'h1;
            conv_clk_en <= 1'b0;
        end
    end

    // Start requests and run conditions
    always_comb begin
        normal_go = (wr_en && wr_lane && wr_idx == IDX_NORM_CTRL && wr_data[B_START])
            || (norm_ctrl[B_HW_EN] && norm_ctrl[1:0] == TRIG_TIMER && timer_trigger_normal)
            || (norm_ctrl[B_HW_EN] && norm_ctrl[1:0] == TRIG_PIN && ext_s2 && !ext_s3);
        pri_go = (wr_en && wr_lane && wr_idx == IDX_PRI_CTRL && wr_data[B_START])
            || (pri_ctrl[B_HW_EN] && pri_ctrl[1:0] == TRIG_TIMER && timer_trigger_priority)
            || (pri_ctrl[B_HW_EN] && pri_ctrl[1:0] == TRIG_PIN && ext_s2 && !ext_s3)
            || (pri_ctrl[B_HW_EN] && pri_ctrl[1:0] == TRIG_AUDIO && audio_sample_tick);
        run_ok = !idle_standby_state || norm_ctrl[B_IDLE_OP];
        last_ch = !ch_mode[B_SCAN] || (nch == ch_mode[6:4]);
        pri_done = conv_done && in_conv && conv_is_pri;
        norm_done = conv_done && in_conv && !conv_is_pri;
    end

    // Sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_active <= 1'b0;
            normal_end_flag <= 1'b0;
            priority_busy_flag <= 1'b0;
            priority_end_flag <= 1'b0;
            pri_pend <= 1'b0;
            in_conv <= 1'b0;
            conv_is_pri <= 1'b0;
            wait_read <= 1'b0;
            nch <= '0;
            conv_start <= 1'b0;
            conv_channel <= '0;
            reference_apply <= 1'b0;
            result_valid <= 1'b0;
            result_channel <= '0;
            result_data <= '0;
        end else begin
            conv_start <= 1'b0;
            result_valid <= 1'b0;
            reference_apply <= ch_mode[B_REF];
            if (normal_go && !seq_active) begin
                seq_active <= 1'b1;
                normal_end_flag <= 1'b0;
                nch <= ch_mode[B_SCAN] ? '0 : ch_mode[6:4];
            end
            if (pri_go && !pri_pend && !priority_busy_flag) begin
                pri_pend <= 1'b1;
                priority_busy_flag <= 1'b1;
                priority_end_flag <= 1'b0;
            end
            if (!in_conv && conv_clk_en && run_ok) begin
                if (pri_pend) begin
                    in_conv <= 1'b1;
                    conv_is_pri <= 1'b1;
                    pri_pend <= 1'b0;
                    conv_start <= 1'b1;
                    conv_channel <= pri_ch[6:4];
                end else if (seq_active && !wait_read) begin
                    in_conv <= 1'b1;
                    conv_is_pri <= 1'b0;
                    conv_start <= 1'b1;
                    conv_channel <= nch;
                end
            end
            if (normal_result_read) begin
                wait_read <= 1'b0;
            end
            if (pri_done) begin
                in_conv <= 1'b0;
                priority_busy_flag <= 1'b0;
                priority_end_flag <= 1'b1;
            end
            if (norm_done) begin
                in_conv <= 1'b0;
                result_valid <= 1'b1;
                result_channel <= conv_channel;
                result_data <= conv_data;
                if (!last_ch) begin
                    nch <= nch + 3'h1;
                end else begin
                    normal_end_flag <= 1'b1;
                    if (ch_mode[B_REPEAT]) begin
                        nch <= ch_mode[B_SCAN] ? '0 : ch_mode[6:4];
                        wait_read <= ch_mode[B_LAT];
                    end else begin
                        seq_active <= 1'b0;
                    end
                end
            end
        end
    end

    // Priority result and its flags; a new store beats a clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            priority_result_bits <= '0;
            priority_stored_flag <= 1'b0;
            priority_overrun_flag <= 1'b0;
        end else if (pri_done) begin
            priority_result_bits <= conv_data;
            priority_stored_flag <= 1'b1;
            if (priority_stored_flag && !rd_pri_hi) begin
                priority_overrun_flag <= 1'b1;
            end
        end else if (rd_pri_hi) begin
            priority_stored_flag <= 1'b0;
            priority_overrun_flag <= 1'b0;
        end
    end

    // Compare monitors
    adc_monitor u_mon0 (
        .enable(mon_ctrl[6]),
        .greater(mon_ctrl[4]),
        .channel(mon_ch[2:0]),
        .criterion(crit0),
        .res_valid(result_valid),
        .res_channel(result_channel),
        .res_data(result_data),
        .hit(mon_hit[0])
    );
    adc_monitor u_mon1 (
        .enable(mon_ctrl[7]),
        .greater(mon_ctrl[5]),
        .channel(mon_ch[6:4]),
        .criterion(crit1),
        .res_valid(result_valid),
        .res_channel(result_channel),
        .res_data(result_data),
        .hit(mon_hit[1])
    );

    // Monitor status and interrupt lines; a hit beats a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_status <= 2'h0;
            monitor0_irq <= 1'b0;
            monitor1_irq <= 1'b0;
        end else begin
            if (wr_en && wr_lane && wr_idx == IDX_MON_CTRL) begin
                mon_status <= (mon_status & wr_data[1:0]) | mon_hit;
            end else begin
                mon_status <= mon_status | mon_hit;
            end
            monitor0_irq <= mon_status[0] && mon_ctrl[2];
            monitor1_irq <= mon_status[1] && mon_ctrl[3];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_pri_issue;
        pri_pend && !in_conv && conv_clk_en && run_ok;
    endsequence
    sequence s_pri_launched;
        conv_start && conv_is_pri;
    endsequence

    property p_end_set;
        norm_done && last_ch && !ch_mode[B_REPEAT] |=> normal_end_flag && !seq_active;
    endproperty
    a_end_set: assert property (p_end_set) else $error("end flag not set");
    property p_start_clears;
        normal_go && !seq_active |=> seq_active && !normal_end_flag;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start not taken");
    property p_overrun;
        pri_done && priority_stored_flag && !rd_pri_hi |=> priority_overrun_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");
    property p_div3;
        conv_clk_en && div_n == 3'h3 && !(wr_en && wr_idx == IDX_CCLK)
            ##1 !(wr_en && wr_idx == IDX_CCLK) [*2] |-> !conv_clk_en ##1 conv_clk_en;
    endproperty
    a_div3: assert property (p_div3) else $error("divide by 3 wrong");
    property p_idle_stop;
        !run_ok |=> !conv_start;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("start during idle");
    property p_pri_first;
        s_pri_issue |=> s_pri_launched;
    endproperty
    a_pri_first: assert property (p_pri_first) else $error("priority not first");
    property p_latency;
        wait_read && !pri_pend && !normal_result_read |=> !conv_start;
    endproperty
    a_latency: assert property (p_latency) else $error("no latency wait");
    property p_pri_end;
        pri_done |=> priority_end_flag && !priority_busy_flag && priority_stored_flag;
    endproperty
    a_pri_end: assert property (p_pri_end) else $error("priority flags wrong");
    property p_mon_irq;
        mon_hit[0] && mon_ctrl[2] |=> mon_status[0] ##1 monitor0_irq;
    endproperty
    a_mon_irq: assert property (p_mon_irq) else $error("monitor irq missing");
endmodule : adc_seq_ctrl

//--- adc_conv_model.sv
// Converter model: answers each start after a fixed latency
// Assumes starts come as one-cycle pulses on aclk
`timescale 1ns/100ps
module adc_conv_model (
    // Converter side
    input wire logic aclk,
    input wire logic conv_start,
    input wire logic [2:0] conv_channel,
    output logic conv_done,
    output logic [9:0] conv_data
);
    logic [3:0] cnt = 4'h0;
    logic [2:0] ch = 3'h0;
    initial conv_done = 1'h0;
    initial conv_data = 10'h000;
    // Data outside the done cycle keeps toggling
    always @(posedge aclk) begin
        conv_done <= (cnt == 4'h1);
        conv_data <= (cnt == 4'h1) ? {ch, 7'h2A} : ~conv_data;
        if (conv_start) begin
            cnt <= 4'h5;
            ch <= conv_channel;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : adc_conv_model

//--- adc_sequencing_control_test.sv
// Testbench for the converter sequencing control block
// Assumes the converter model and an AXI4-Lite master task set
`timescale 1ns/100ps
module adc_sequencing_control_test;
    import adc_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, tn = 1'h0, tp = 1'h0, au = 1'h0, pin = 1'h0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, irq0, irq1, clk_en, cst, ref_ap, done, rv;
    logic [1:0] bresp, rresp, rr;
    logic [2:0] cch, rch;
    logic [9:0] cdat, rdat;
    logic [7:0] d;
    logic idle = 1'h0;
    int miscompares = 0, cmp_count = 0, nres = 0, n;
    adc_seq_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer_trigger_normal(tn), .timer_trigger_priority(tp), .audio_sample_tick(au),
        .external_trigger_pin(pin), .idle_standby_state(idle), .conv_clk_en(clk_en),
        .conv_start(cst), .conv_channel(cch), .reference_apply(ref_ap), .conv_done(done),
        .conv_data(cdat), .result_valid(rv), .result_channel(rch), .result_data(rdat),
        .normal_result_read(1'h0), .monitor0_irq(irq0), .monitor1_irq(irq1));
    adc_conv_model conv (.aclk(aclk), .conv_start(cst), .conv_channel(cch),
        .conv_done(done), .conv_data(cdat));
    initial begin
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (rv === 1'h1) begin
            nres++;
            chk(rdat, {rch, 7'h2A});
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            miscompares++;
        end
    endtask : chk
    task wr(input logic [13:0] i, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
    endtask : wr
    task rd(input logic [13:0] i);
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        d = rdata[7:0];
        rr = rresp;
    endtask : rd
    task wait_end(input logic [13:0] i);
        repeat (100) begin
            rd(i);
            if (d[B_END] === 1'h1) break;
        end
    endtask : wait_end
    task t_reset;
        logic [13:0] idx [13];
        idx = '{IDX_PRI_RES_LO, IDX_PRI_RES_HI, IDX_CMP0_LO, IDX_CMP0_HI, IDX_CMP1_LO,
            IDX_CMP1_HI, IDX_NORM_CTRL, IDX_CH_MODE, IDX_PRI_CTRL, IDX_PRI_CH, IDX_MON_CTRL,
            IDX_MON_CH, IDX_CCLK};
        foreach (idx[k]) begin
            rd(idx[k]);
            chk(d, REG_RESET);
        end
        rd(14'h12B2);
        chk(rr, RESP_SLVERR);
    endtask : t_reset
    task t_cmp;
        wr(IDX_CMP1_LO, 8'hC0);
        wr(IDX_CMP1_HI, 8'hA5);
        rd(IDX_CMP1_LO);
        chk(d, 8'hC0);
        rd(IDX_CMP1_HI);
        chk(d, 8'hA5);
    endtask : t_cmp
    task t_clk;
        wr(IDX_CCLK, 8'h03);
        rd(IDX_CCLK);
        chk(d, 8'h03);
        n = 0;
        repeat (30) begin
            @(posedge aclk);
            if (clk_en === 1'h1) n++;
        end
        chk(n, 10);
        wr(IDX_CCLK, 8'h01);
    endtask : t_clk
    task t_normal;
        wr(IDX_CH_MODE, 8'hA1);
        @(posedge aclk);
        chk(ref_ap, 1'h1);
        nres = 0;
        wr(IDX_NORM_CTRL, 8'h08);
        rd(IDX_NORM_CTRL);
        chk(d, 8'h40);
        wait_end(IDX_NORM_CTRL);
        chk(d, 8'h80);
        chk(nres, 3);
    endtask : t_normal
    task t_pri;
        wr(IDX_PRI_CH, 8'h50);
        repeat (2) begin
            wr(IDX_PRI_CTRL, 8'h08);
            wait_end(IDX_PRI_CTRL);
            chk(d, 8'h80);
        end
        rd(IDX_PRI_RES_LO);
        chk(d, 8'h83);
        rd(IDX_PRI_RES_HI);
        chk(d, 8'hAA);
        rd(IDX_PRI_RES_LO);
        chk(d, 8'h80);
    endtask : t_pri
    task t_trig;
        logic [1:0] code [3];
        code = '{TRIG_TIMER, TRIG_PIN, TRIG_AUDIO};
        foreach (code[k]) begin
            wr(IDX_PRI_CTRL, {6'h01, code[k]});
            tp <= (code[k] == TRIG_TIMER);
            pin <= (code[k] == TRIG_PIN);
            au <= (code[k] == TRIG_AUDIO);
            @(posedge aclk);
            tp <= 1'h0;
            au <= 1'h0;
            repeat (3) @(posedge aclk);
            pin <= 1'h0;
            wait_end(IDX_PRI_CTRL);
            chk(d[B_END], 1'h1);
            rd(IDX_PRI_RES_LO);
            chk(d, 8'h81);
            rd(IDX_PRI_RES_HI);
        end
        wr(IDX_PRI_CTRL, 8'h00);
    endtask : t_trig
    task t_mon;
        wr(IDX_CH_MODE, 8'h30);
        wr(IDX_CMP0_LO, 8'h80);
        wr(IDX_CMP0_HI, 8'h6A);
        wr(IDX_MON_CH, 8'h03);
        wr(IDX_MON_CTRL, 8'h44);
        wr(IDX_NORM_CTRL, 8'h04);
        tn <= 1'h1;
        @(posedge aclk);
        tn <= 1'h0;
        wait_end(IDX_NORM_CTRL);
        repeat (2) @(posedge aclk);
        chk(irq0, 1'h1);
        chk(irq1, 1'h0);
        rd(IDX_MON_CTRL);
        chk(d, 8'h45);
        wr(IDX_MON_CTRL, 8'h44);
        rd(IDX_MON_CTRL);
        chk(d, 8'h44);
        chk(irq0, 1'h0);
    endtask : t_mon
    task t_idle;
        idle <= 1'h1;
        wr(IDX_NORM_CTRL, 8'h08);
        repeat (20) @(posedge aclk);
        rd(IDX_NORM_CTRL);
        chk(d, 8'h40);
        wr(IDX_NORM_CTRL, 8'h18);
        wait_end(IDX_NORM_CTRL);
        chk(d, 8'h90);
        idle <= 1'h0;
    endtask : t_idle
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_cmp;
        t_clk;
        t_normal;
        t_pri;
        t_trig;
        t_mon;
        t_idle;
        give_verdict;
    end
    initial begin
        #200000;
        miscompares++;
        give_verdict;
    end
endmodule : adc_sequencing_control_test
